// ---- rtl/cmd_seq.sv ----
// Command sequencer with status reporting top and Avalon-MM register slave.
// Assumes input unit, hardware and talker logic all run on sys_clk.
//
// Behaviour
// - Commands handled in arrival order; clear first
// - Syntax errors reported, line analysis continues
// - Separator, terminator apply settings; clear request discards pending ones
// - Settings stored; forwarded only on apply
// - Check before transfer; error rolls back
// - Query places stored setting in output buffer
// - Talker with nothing pending: query error
// - Operation complete sets event bit 0
// - Completion query writes 1 once settled
// - Wait command stalls handshake until settled
// - Status byte and enable top hierarchy
// - Individual flag masked by poll enable
// - Message-available bit follows output buffer
// - Status registers: five 16-bit parts
// - Bit 15 of every part reads zero
// - Operation bit 3 means waiting for trigger
// - Errors queued; queue and registers readable
// - Transition filters decide which edges latch
// - Event read returns contents then clears
// - Enabled events ORed into summary bit
// - Condition part read-only, follows live state
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`include "cmd_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cmd_seq (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    // Avalon-MM slave
    input  wire logic [7:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    output logic [31:0]                   readdata,
    output logic                          waitrequest,
    // Items from the input unit
    input  wire logic                     cmd_valid,
    input  wire cmd_seq_pkg::cmd_kind_t   cmd_kind,
    input  wire logic [15:0]              cmd_data,
    output logic                          cmd_ready,
    input  wire logic                     dev_clear,
    // Hardware side
    output logic                          hw_set_valid,
    output logic [15:0]                   hw_set_data,
    input  wire logic                     hw_done,
    output logic                          trigger,
    // Live conditions
    input  wire logic                     trig_waiting,
    input  wire logic [14:0]              oper_cond_in,
    input  wire logic [14:0]              ques_cond_in,
    // Talker side
    input  wire logic                     talk_req,
    output logic                          talk_valid,
    output logic [15:0]                   talk_data,
    // Status outputs
    output logic                          srq,
    output logic                          individual_status_flag,
    output logic                          settled
);
    cmd_seq_pkg::state_t s;
    cmd_seq_pkg::state_t next_s;
    logic [7:0]          stb;
    logic [1:0]          summ;
    logic                req;
    logic                acc;
    logic                take;

    // Latch enabled transitions into the event part
    function automatic logic [15:0] edge_set(input logic [15:0] old_c, input logic [15:0] new_c,
                                             input logic [15:0] p, input logic [15:0] n);
        edge_set = ((~old_c & new_c & p) | (old_c & ~new_c & n)) & 16'h7fff;
    endfunction

    // Append an error code; a full queue keeps its oldest entries
    function automatic cmd_seq_pkg::state_t push_err(input cmd_seq_pkg::state_t st,
                                                     input logic [7:0] code);
        push_err = st;
        if (st.eq_cnt != `ERRQ_DEPTH) begin
            push_err.eq[st.eq_cnt[1:0]] = code;
            push_err.eq_cnt = st.eq_cnt + 3'h1;
        end
    endfunction

    // Read mux for one five-part register
    function automatic logic [15:0] part_rd(input cmd_seq_pkg::state_t st, input int unsigned r,
                                            input logic [2:0] part);
        case (part)
            `PART_COND: part_rd = st.cond[r];
            `PART_PTR:  part_rd = st.ptr[r];
            `PART_NTR:  part_rd = st.ntr[r];
            `PART_EVT:  part_rd = st.evt[r];
            `PART_ENA:  part_rd = st.ena[r];
            default:    part_rd = 16'h0000;
        endcase
    endfunction

    // Summaries and status byte; bit 6 summarises the others
    always_comb begin
        for (int r = 0; r < 2; r++) begin
            summ[r] = |(s.evt[r] & s.ena[r]);
        end
        stb = 8'h00;
        stb[`STB_EQ]   = (s.eq_cnt != 3'h0);
        stb[`STB_QUES] = summ[1];
        stb[`STB_MAV]  = s.out_full;
        stb[`STB_ESB]  = |(s.esr & s.ese);
        stb[`STB_OPER] = summ[0];
        stb[`STB_MSS]  = |(stb & s.sre & 8'hbf);
    end

    // Handshake outputs; a wait command or a clear holds the input unit off
    assign req         = read | write;
    assign acc         = req & ~s.ack;
    assign waitrequest = req & ~s.ack;
    assign cmd_ready   = ~s.wai & ~dev_clear;
    assign take        = cmd_valid & cmd_ready;
    assign settled     = ~s.outstanding & ~s.dirty;

    // Next-state logic for the whole block
    always_comb begin
        logic [15:0] new_c;
        logic        do_apply;
        new_c    = 16'h0000;
        do_apply = 1'b0;
        next_s = s;
        next_s.ack        = acc;
        next_s.hw_valid   = 1'b0;
        next_s.trig       = 1'b0;
        next_s.talk_valid = 1'b0;

        // Condition parts track live state only
        for (int r = 0; r < 2; r++) begin
            if (r == 0) begin
                new_c = {1'b0, oper_cond_in[14:4], trig_waiting, oper_cond_in[2:0]};
            end else begin
                new_c = {1'b0, ques_cond_in};
            end
            next_s.cond[r] = new_c;
        end

        // Transfer bookkeeping from the hardware
        if (hw_done) begin
            next_s.outstanding = 1'b0;
        end

        // Completion actions wait for the hardware to settle
        if (settled && s.opc_wait) begin
            next_s.opc_wait = 1'b0;
            next_s.esr[`ESR_OPC] = 1'b1;
        end
        if (settled && s.opcq_wait && !s.out_full) begin
            next_s.opcq_wait = 1'b0;
            next_s.out_full  = 1'b1;
            next_s.out_data  = `OPC_REPLY;
        end
        if (settled && s.wai) begin
            next_s.wai = 1'b0;
        end

        // Recognizer: one item per cycle, strictly in order
        if (dev_clear) begin
            next_s.pend_set  = s.applied_set;
            next_s.dirty     = 1'b0;
            next_s.opc_wait  = 1'b0;
            next_s.opcq_wait = 1'b0;
            next_s.wai       = 1'b0;
            next_s.out_full  = 1'b0;
        end else if (take) begin
            case (cmd_kind)
                cmd_seq_pkg::K_SET: begin
                    next_s.pend_set = cmd_data;
                    next_s.dirty    = 1'b1;
                end
                cmd_seq_pkg::K_QRY: begin
                    next_s.out_full = 1'b1;
                    next_s.out_data = s.pend_set;
                end
                cmd_seq_pkg::K_SEP, cmd_seq_pkg::K_TERM: begin
                    do_apply = s.dirty;
                end
                cmd_seq_pkg::K_GET: begin
                    next_s.trig = 1'b1;
                end
                cmd_seq_pkg::K_OPC: begin
                    next_s.opc_wait = 1'b1;
                end
                cmd_seq_pkg::K_OPCQ: begin
                    next_s.opcq_wait = 1'b1;
                end
                cmd_seq_pkg::K_WAI: begin
                    next_s.wai = ~settled;
                end
                cmd_seq_pkg::K_SERR: begin
                    next_s.esr[`ESR_CME] = 1'b1;
                    next_s = push_err(next_s, `ERR_SYNTAX);
                end
                default: begin
                    next_s.esr[`ESR_CME] = 1'b1;
                end
            endcase
        end

        // Consistency check just before transfer; failure rolls back
        if (do_apply) begin
            next_s.dirty = 1'b0;
            if (s.pend_set > s.limit) begin
                next_s.pend_set = s.applied_set;
                next_s.esr[`ESR_EXE] = 1'b1;
                next_s = push_err(next_s, `ERR_EXEC);
            end else begin
                next_s.applied_set = s.pend_set;
                next_s.hw_valid    = 1'b1;
                next_s.hw_data     = s.pend_set;
                next_s.outstanding = 1'b1;
            end
        end

        // Talker addressed: send buffer, wait for pending reply, or flag
        if (talk_req && !dev_clear) begin
            if (s.out_full) begin
                next_s.talk_valid = 1'b1;
                next_s.talk_data  = s.out_data;
                next_s.out_full   = take && (cmd_kind == cmd_seq_pkg::K_QRY);
            end else if (!s.opcq_wait && !(take && cmd_kind == cmd_seq_pkg::K_QRY)) begin
                next_s.esr[`ESR_QYE] = 1'b1;
                next_s = push_err(next_s, `ERR_QUERY);
            end
        end

        // Register bus access; the answer stands one cycle after the request
        // Reads act when taken; writes land at the edge that completes the access
        if ((acc && read) || (write && s.ack)) begin
            next_s.rdata = 32'h0000_0000;
            if (address >= `OFS_OPER && address < `OFS_QUES + 8'h14 && address[1:0] == 2'h0) begin
                for (int r = 0; r < 2; r++) begin
                    if (address[7:5] == (3'h1 + 3'(r))) begin
                        if (read) begin
                            next_s.rdata = {16'h0000, part_rd(s, r, address[4:2])};
                            if (address[4:2] == `PART_EVT) begin
                                next_s.evt[r] = 16'h0000;
                            end
                        end else begin
                            case (address[4:2])
                                `PART_PTR: next_s.ptr[r] = writedata[15:0] & 16'h7fff;
                                `PART_NTR: next_s.ntr[r] = writedata[15:0] & 16'h7fff;
                                `PART_ENA: next_s.ena[r] = writedata[15:0] & 16'h7fff;
                                default: ;
                            endcase
                        end
                    end
                end
            end else begin
                case (address)
                    `OFS_STB: next_s.rdata = {24'h0, stb};
                    `OFS_SRE: begin
                        next_s.rdata = {24'h0, s.sre};
                        if (write) next_s.sre = writedata[7:0] & 8'hbf;
                    end
                    `OFS_ESR: if (read) begin
                        next_s.rdata = {24'h0, s.esr};
                        next_s.esr = next_s.esr & ~s.esr; // Bits set this cycle survive
                    end
                    `OFS_ESE: begin
                        next_s.rdata = {24'h0, s.ese};
                        if (write) next_s.ese = writedata[7:0];
                    end
                    `OFS_POLL_EN: begin
                        next_s.rdata = {24'h0, s.poll_mask};
                        if (write) next_s.poll_mask = writedata[7:0];
                    end
                    `OFS_ERRQ: if (read && s.eq_cnt != 3'h0) begin
                        next_s.rdata = {24'h0, s.eq[0]};
                        next_s.eq = {8'h00, next_s.eq[3:1]}; // Keeps a same-cycle push
                        next_s.eq_cnt = next_s.eq_cnt - 3'h1;
                    end
                    `OFS_MISC: next_s.rdata = {28'h0, s.outstanding, s.dirty, settled,
                                               individual_status_flag};
                    `OFS_LIMIT: begin
                        next_s.rdata = {16'h0, s.limit};
                        if (write) next_s.limit = writedata[15:0];
                    end
                    default: next_s.rdata = 32'h0000_0000;
                endcase
            end
            if (write) next_s.rdata = 32'h0000_0000;
        end

        // Edge filters last, so a new event beats a read-clear
        for (int r = 0; r < 2; r++) begin
            next_s.evt[r] = next_s.evt[r] | edge_set(s.cond[r], next_s.cond[r], s.ptr[r],
                                                     s.ntr[r]);
        end
    end

    // Single state register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s       <= '0;
            s.limit <= `RST_LIMIT;
            s.ptr   <= {`RST_PTR, `RST_PTR};
        end else begin
            s <= next_s;
        end
    end

    // Registered data outputs; status flags decoded combinationally from the state
    assign readdata               = s.rdata;
    assign hw_set_valid           = s.hw_valid;
    assign hw_set_data            = s.hw_data;
    assign trigger                = s.trig;
    assign talk_valid             = s.talk_valid;
    assign talk_data              = s.talk_data;
    assign srq                    = stb[`STB_MSS];
    assign individual_status_flag = |(stb & s.poll_mask);

endmodule // cmd_seq

`default_nettype wire

// ---- rtl/cmd_seq_defs.svh ----
// Offsets, field positions, reset values and codes of the command sequencer.
// Assumes inclusion by bare name from the package or module that needs them.
`ifndef CMD_SEQ_DEFS_SVH
`define CMD_SEQ_DEFS_SVH
// Register byte addresses on the Avalon slave
`define OFS_STB       8'h00
`define OFS_SRE       8'h04
`define OFS_ESR       8'h08
`define OFS_ESE       8'h0c
`define OFS_POLL_EN   8'h10
`define OFS_ERRQ      8'h14
`define OFS_MISC      8'h18
`define OFS_LIMIT     8'h1c
`define OFS_OPER      8'h20
`define OFS_QUES      8'h40
// Part offsets inside one five-part status register
`define PART_COND     3'h0
`define PART_PTR      3'h1
`define PART_NTR      3'h2
`define PART_EVT      3'h3
`define PART_ENA      3'h4
// Event register bits
`define ESR_OPC       0
`define ESR_QYE       2
`define ESR_EXE       4
`define ESR_CME       5
// Status byte bits, then the operation register's wait-for-trigger bit
`define STB_EQ        2
`define STB_QUES      3
`define STB_MAV       4
`define STB_ESB       5
`define STB_MSS       6
`define STB_OPER      7
`define OPER_WTRIG    3
// Reset values and the completion query reply
`define RST_LIMIT     16'h7fff
`define RST_PTR       16'h7fff
`define OPC_REPLY     16'h0001
// Error queue codes, values arbitrary, then the queue depth
`define ERR_SYNTAX    8'h01
`define ERR_EXEC      8'h02
`define ERR_QUERY     8'h03
`define ERRQ_DEPTH    3'h4
`endif

// ---- rtl/cmd_seq_pkg.sv ----
// Types shared by the command sequencer and its bench.
// Assumes nothing beyond the defines header.
package cmd_seq_pkg;
    // Kind of item handed over by the input unit
    typedef enum logic [3:0] {
        K_SET  = 4'h0,
        K_QRY  = 4'h1,
        K_SEP  = 4'h2,
        K_TERM = 4'h3,
        K_GET  = 4'h4,
        K_OPC  = 4'h5,
        K_OPCQ = 4'h6,
        K_WAI  = 4'h7,
        K_SERR = 4'h8
    } cmd_kind_t;

    typedef struct packed {
        logic             ack;
        logic [31:0]      rdata;
        logic [15:0]      pend_set;
        logic [15:0]      applied_set;
        logic             dirty;
        logic             outstanding;
        logic             hw_valid;
        logic [15:0]      hw_data;
        logic             trig;
        logic             opc_wait;
        logic             opcq_wait;
        logic             wai;
        logic             out_full;
        logic [15:0]      out_data;
        logic             talk_valid;
        logic [15:0]      talk_data;
        logic [7:0]       esr;
        logic [7:0]       ese;
        logic [7:0]       sre;
        logic [7:0]       poll_mask;
        logic [15:0]      limit;
        logic [1:0][15:0] cond;
        logic [1:0][15:0] ptr;
        logic [1:0][15:0] ntr;
        logic [1:0][15:0] evt;
        logic [1:0][15:0] ena;
        logic [3:0][7:0]  eq;
        logic [2:0]       eq_cnt;
    } state_t;
endpackage

// ---- verification/hw_model.sv ----
// Model of the instrument hardware that takes setting transfers.
// Assumes one clock; done comes dly cycles after the latest transfer pulse.
`timescale 1ns/1ps
`default_nettype none
module hw_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       hw_set_valid,
    input  wire logic [3:0] dly,
    output logic            hw_done
);
    logic [3:0] cnt;
    logic       busy;
    // Settling countdown; a new transfer restarts it, as real hardware would
    always_ff @(posedge sys_clk) begin
        hw_done <= 1'b0;
        if (!rst_b) begin
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (hw_set_valid) begin
            busy <= 1'b1;
            cnt <= dly;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt <= 4'h1) begin
                busy <= 1'b0;
                hw_done <= 1'b1;
            end
        end
    end
endmodule // hw_model
`default_nettype wire

// ---- verification/cmd_seq_properties.sv ----
// Port-level checks of the command sequencer.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cmd_seq_properties (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic                   waitrequest,
    input  wire logic                   cmd_valid,
    input  wire cmd_seq_pkg::cmd_kind_t cmd_kind,
    input  wire logic                   cmd_ready,
    input  wire logic                   dev_clear,
    input  wire logic                   hw_set_valid,
    input  wire logic                   hw_done,
    input  wire logic                   trigger,
    input  wire logic                   settled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Item taken this cycle
    logic take;
    assign take = cmd_valid && cmd_ready && !dev_clear;
    property p_ack_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("access not answered");
    property p_wait_idle;
        waitrequest |-> read || write;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("stray waitrequest");
    property p_get_trig;
        take && cmd_kind == cmd_seq_pkg::K_GET |=> trigger;
    endproperty
    a_get_trig: assert property (p_get_trig) else $error("trigger missing");
    property p_trig_cause;
        trigger |-> $past(take && cmd_kind == cmd_seq_pkg::K_GET);
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger uncaused");
    property p_clear_blocks;
        dev_clear |-> !cmd_ready;
    endproperty
    a_clear_blocks: assert property (p_clear_blocks) else $error("ready in clear");
    property p_apply_cause;
        hw_set_valid |-> $past(take && (cmd_kind == cmd_seq_pkg::K_SEP
            || cmd_kind == cmd_seq_pkg::K_TERM));
    endproperty
    a_apply_cause: assert property (p_apply_cause) else $error("apply uncaused");
    property p_busy_apply;
        hw_set_valid |-> !settled;
    endproperty
    a_busy_apply: assert property (p_busy_apply) else $error("settled in apply");
    property p_busy_hold;
        hw_set_valid ##1 !hw_done |-> !settled;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("settled too early");
    property p_wai_stall;
        take && cmd_kind == cmd_seq_pkg::K_WAI && !settled |=> !cmd_ready;
    endproperty
    a_wai_stall: assert property (p_wai_stall) else $error("wait did not stall");
endmodule // cmd_seq_properties
bind cmd_seq cmd_seq_properties i_cmd_seq_properties (.sys_clk(sys_clk), .rst_b(rst_b),
    .read(read), .write(write), .waitrequest(waitrequest), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .dev_clear(dev_clear),
    .hw_set_valid(hw_set_valid), .hw_done(hw_done), .trigger(trigger), .settled(settled));
`default_nettype wire

// ---- verification/cmd_seq_bench.sv ----
// Self-checking bench of the command sequencer.
// Assumes the checker is bound in and hw_model answers the transfers.
`include "cmd_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module cmd_seq_bench;
    logic                    sys_clk = 1'b0;
    logic                    rst_b = 1'b0;
    logic [7:0]              address = 8'h00;
    logic                    read = 1'b0;
    logic                    write = 1'b0;
    logic [31:0]             writedata = 32'h0, readdata, q;
    logic                    waitrequest, cmd_ready, hw_set_valid, hw_done, trigger;
    logic                    cmd_valid = 1'b0, dev_clear = 1'b0, trig_waiting = 1'b0;
    cmd_seq_pkg::cmd_kind_t  cmd_kind = cmd_seq_pkg::K_SET;
    logic [15:0]             cmd_data = 16'h0, hw_set_data, talk_data;
    logic [14:0]             oper_cond_in = 15'h0, ques_cond_in = 15'h0;
    logic                    talk_req = 1'b0, talk_valid, srq, status_flag, settled;
    logic [3:0]              dly = 4'h9;
    int                      err_total = 0, comparisons = 0, napp = 0;
    always #25 sys_clk = ~sys_clk;
    cmd_seq i_cmd_seq (.sys_clk(sys_clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .dev_clear(dev_clear),
        .hw_set_valid(hw_set_valid), .hw_set_data(hw_set_data), .hw_done(hw_done),
        .trigger(trigger), .trig_waiting(trig_waiting), .oper_cond_in(oper_cond_in),
        .ques_cond_in(ques_cond_in), .talk_req(talk_req), .talk_valid(talk_valid),
        .talk_data(talk_data), .srq(srq), .individual_status_flag(status_flag),
        .settled(settled));
    hw_model i_hw_model (.sys_clk(sys_clk), .rst_b(rst_b), .hw_set_valid(hw_set_valid),
        .dly(dly), .hw_done(hw_done));
    // Transfers seen on the hardware side
    always @(posedge sys_clk) if (hw_set_valid === 1'b1) napp <= napp + 1;
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge; bounded wait
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n == 20) err_total++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        av(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic send(input cmd_seq_pkg::cmd_kind_t k, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_data <= d;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 40);
        if (n == 40) err_total++;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask
    // One talker request; the word, if any, stands one cycle later
    task automatic talk(input logic v, input logic [15:0] e);
        @(posedge sys_clk);
        talk_req <= 1'b1;
        @(posedge sys_clk);
        talk_req <= 1'b0;
        @(negedge sys_clk);
        chk(talk_valid, v);
        if (v) chk(talk_data, e);
    endtask
    task automatic settle;
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (settled !== 1'b1 && n < 40);
        chk(n < 40, 1'b1);
        repeat (2) @(posedge sys_clk);
    endtask
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(4000 * 50);
        err_total++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(`OFS_LIMIT, 32'h7fff);
        rd(`OFS_OPER + 8'h04, 32'h7fff);
        rd(8'hfc, 32'h0);
        av(1'b1, `OFS_QUES + 8'h08, 32'hffff);
        rd(`OFS_QUES + 8'h08, 32'h7fff);
        av(1'b1, `OFS_QUES, 32'hffff);
        rd(`OFS_QUES, 32'h0);
        av(1'b1, `OFS_SRE, 32'hff);
        rd(`OFS_SRE, 32'hbf);
        send(cmd_seq_pkg::K_SET, 16'h5);
        chk(napp, 0);
        send(cmd_seq_pkg::K_TERM, 16'h0);
        @(negedge sys_clk);
        chk(settled, 1'b0);
        settle;
        chk(hw_set_data, 16'h5);
        av(1'b1, `OFS_LIMIT, 32'h10);
        send(cmd_seq_pkg::K_SET, 16'h20);
        send(cmd_seq_pkg::K_TERM, 16'h0);
        repeat (3) @(posedge sys_clk);
        chk({napp[7:0], hw_set_data}, 24'h010005);
        rd(`OFS_ESR, 32'h10);
        rd(`OFS_ERRQ, 32'h2);
        send(cmd_seq_pkg::K_SERR, 16'h0);
        send(cmd_seq_pkg::K_QRY, 16'h0);
        talk(1'b1, 16'h5);
        rd(`OFS_ESR, 32'h20);
        rd(`OFS_ESR, 32'h0);
        rd(`OFS_ERRQ, 32'h1);
        talk(1'b0, 16'h0);
        rd(`OFS_ESR, 32'h4);
        rd(`OFS_ERRQ, 32'h3);
        rd(`OFS_ERRQ, 32'h0);
        av(1'b1, `OFS_ESE, 32'h1);
        av(1'b1, `OFS_SRE, 32'h20);
        dly <= 4'h1;
        send(cmd_seq_pkg::K_SET, 16'h7);
        send(cmd_seq_pkg::K_SEP, 16'h0);
        send(cmd_seq_pkg::K_OPC, 16'h0);
        settle;
        chk(srq, 1'b1);
        rd(`OFS_ESR, 32'h1);
        chk(srq, 1'b0);
        dly <= 4'h9;
        send(cmd_seq_pkg::K_SET, 16'h8);
        send(cmd_seq_pkg::K_TERM, 16'h0);
        send(cmd_seq_pkg::K_OPCQ, 16'h0);
        talk(1'b0, 16'h0);
        settle;
        rd(`OFS_STB, 32'h10);
        talk(1'b1, 16'h1);
        rd(`OFS_ESR, 32'h0);
        send(cmd_seq_pkg::K_SET, 16'h9);
        send(cmd_seq_pkg::K_TERM, 16'h0);
        send(cmd_seq_pkg::K_WAI, 16'h0);
        @(negedge sys_clk);
        chk(cmd_ready, 1'b0);
        send(cmd_seq_pkg::K_GET, 16'h0);
        @(negedge sys_clk);
        chk({trigger, settled}, 2'b11);
        av(1'b1, `OFS_OPER + 8'h10, 32'h8);
        trig_waiting <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(`OFS_OPER, 32'h8);
        rd(`OFS_STB, 32'h80);
        av(1'b1, `OFS_POLL_EN, 32'h80);
        @(negedge sys_clk);
        chk(status_flag, 1'b1);
        rd(`OFS_OPER + 8'h0c, 32'h8);
        rd(`OFS_OPER + 8'h0c, 32'h0);
        av(1'b1, `OFS_OPER + 8'h04, 32'h0);
        av(1'b1, `OFS_OPER + 8'h08, 32'h8);
        trig_waiting <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(`OFS_OPER + 8'h0c, 32'h8);
        send(cmd_seq_pkg::K_SET, 16'h3);
        dev_clear <= 1'b1;
        @(posedge sys_clk);
        dev_clear <= 1'b0;
        send(cmd_seq_pkg::K_TERM, 16'h0);
        repeat (3) @(posedge sys_clk);
        chk(napp, 4);
        stop_test;
    end
endmodule // cmd_seq_bench
`default_nettype wire
